/* File: core/bmf_pkg.sv */
// Shared constants, state codes and carriers of the broadband framing block.
// Assumes a single 125 MHz system clock; every count below is in bit times.
package bmf_pkg;

    // Transmit framing lengths, in bits.
    localparam logic [5:0] MAX_LEAD_DROP   = 6'h05;
    localparam logic [5:0] SYNC_BITS       = 6'h14;
    localparam logic [5:0] UMD_BITS        = 6'h02;
    localparam logic [5:0] POST_BITS       = 6'h17;
    localparam logic [5:0] SQE_DELAY_BITS  = 6'h23;
    localparam logic [5:0] SQE_BITS        = 6'h1e;

    // Scrambler length and feedback taps (delays 18 and 23).
    localparam int         SCR_LEN         = 23;
    localparam int         SCR_TAP_A       = 18;
    localparam int         SCR_TAP_B       = 23;

    // Receive framing: descrambler settling run, marks and line patterns.
    localparam logic [5:0] DESCR_SYNC_BITS = 6'h17;
    localparam logic [5:0] UMD_MARK        = 6'h14;
    localparam logic [22:0] POSTAMBLE      = 23'h3fffff;

    // Transmit sequencer states; codes 6 and 7 are illegal.
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_SYNC = 3'h1,
        TX_UMD  = 3'h2,
        TX_SCR  = 3'h3,
        TX_POST = 3'h4,
        TX_SQE  = 3'h5
    } bmf_tx_state_e;

    // Receive reframing states.
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_SYNC = 2'h1,
        RX_FILL = 2'h2,
        RX_DATA = 2'h3
    } bmf_rx_state_e;

    // One rebuilt bit toward the Manchester encoder of circuit DI.
    typedef struct packed {
        logic first;
        logic data;
    } bmf_di_word_s;

endpackage : bmf_pkg

/* File: core/bmf_framing.sv */
// Framing and line coding of a broadband attachment unit, transmit and receive.
// Assumes a free-running bit clock pin, a demodulator delivering raw bits with
// valid/ready on the system clock, and a Manchester encoder draining DI words.
`timescale 1ns/1ps

// Contract
// - Decode Manchester DO into plain NRZ bits.
// - Drop at most five leading bits.
// - Forward twenty sync bits from first zero.
// - Next two bits become zeros, delimiter.
// - Scramble every bit after the delimiter.
// - Append zero plus twenty-two ones postamble.
// - Postamble may be extended for turnoff.
// - Invert every bit before differential encoding.
// - Differentially encode everything sent to modulator.
// - Send SQE test burst after each packet.
// - Fresh scrambler seed for every packet.
// - Encoding equals division by six-tap generator; the code feeds back over taps 18 and 23 only.
// - Decode, invert received bits; modem recovers clock.
// - Force recovered data to one without carrier.
// - Lose at most six, gain one bit.
// - Delimiter starts local fill after fixed delay.
// - Descrambler self-synchronizes, needs no seed.
// - Descrambler valid within 23 bits of delimiter.
// - Pass descrambled data from 24th bit on.
// - Decoding equals multiplication by same generator.
// - Postamble or carrier loss ends packet cleanly.
// - One bit time is 100 ns; the bench bit clock runs at 160 ns.
// - SQE burst lasts thirty bit times.
// - SQE starts 35 bits after postamble start.
module bmf_framing
    import bmf_pkg::*;
#(
    parameter int POST_EXT  = 5,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         bit_clk,
    input  wire logic         do_line,
    output logic              mod_bit,
    output logic              mod_strobe,
    output logic              mod_on,
    output logic              ce_on,
    input  wire logic         rx_valid,
    input  wire logic         rx_raw,
    input  wire logic         rx_carrier,
    input  wire logic         ce_detect,
    output logic              rx_ready,
    output logic              di_valid,
    input  wire logic         di_ready,
    output bmf_di_word_s      di_word
);

    localparam logic [5:0] POST_ALL = 6'(POST_BITS + 6'(POST_EXT));
    localparam logic [5:0] HOLD_LEN = POST_BITS - 6'h01;
    localparam int         PW       = $clog2(BUF_DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and Manchester decoding.

    logic [2:0]            bclk_s;
    logic [2:0]            do_s;
    logic                  half1;
    logic                  rise;
    logic                  fall;
    logic                  bit_ok;
    logic                  bit_val;

    // Clock and data pass the same three stages, so they stay aligned.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bclk_s <= 3'h0;
            do_s   <= 3'h0;
        end else begin
            bclk_s <= {bclk_s[1:0], bit_clk};
            do_s   <= {do_s[1:0], do_line};
        end
    end

    // The third stage is the line value just before each bit clock edge.
    assign rise    = bclk_s[1] & ~bclk_s[2];
    assign fall    = ~bclk_s[1] & bclk_s[2];
    assign bit_ok  = half1 != do_s[2];  // No mid-cell transition ends the frame.
    assign bit_val = do_s[2];

    // First half cell is caught at the falling edge, second at the next rise.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            half1 <= 1'b0;
        end else if (fall) begin
            half1 <= do_s[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit sequencer: sync run, delimiter, scrambled body, postamble, SQE.

    bmf_tx_state_e         tx_state;
    logic [5:0]            tx_cnt;
    logic [5:0]            drop_cnt;
    logic [SCR_LEN-1:0]    scr;
    logic [SCR_LEN-1:0]    seed_ctr;
    logic                  scr_b;
    logic                  tx_go;
    logic                  tx_e;
    logic                  tx_plain;

    // Feedback over delays 18 and 23, then inversion and differential coding.
    assign scr_b = bit_val ^ scr[SCR_TAP_A-1] ^ scr[SCR_TAP_B-1];

    // The seed counter free-runs, so packets starting apart get other seeds.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            seed_ctr <= 23'h000001;
        end else begin
            seed_ctr <= seed_ctr + 23'h000001;
        end
    end

    // Bit chosen for the modulator on each bit clock rise, before inversion.
    always_comb begin
        tx_go = 1'b0;
        tx_e  = 1'b1;
        if (rise) begin
            unique case (tx_state)
                TX_IDLE: begin
                    tx_go = bit_ok && !bit_val;
                    tx_e  = 1'b0;
                end
                TX_SYNC, TX_UMD, TX_SCR: begin
                    tx_go = 1'b1;
                    if (!bit_ok) begin
                        tx_e = 1'b0;
                    end else if (tx_state == TX_SYNC) begin
                        tx_e = bit_val;
                    end else if (tx_state == TX_UMD) begin
                        tx_e = 1'b0;
                    end else begin
                        tx_e = scr_b;
                    end
                end
                TX_POST: begin
                    tx_go = tx_cnt < POST_ALL;
                    tx_e  = 1'b1;
                end
                TX_SQE: begin
                    tx_go = 1'b0;
                end
                default: begin
                    tx_go = 1'b0;
                end
            endcase
        end
    end

    // Sequencer steps once per bit time, so every count is in bit times.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tx_state <= TX_IDLE;
            tx_cnt   <= 6'h00;
            drop_cnt <= 6'h00;
            scr      <= 23'h000000;
            ce_on    <= 1'b0;
        end else if (rise) begin
            unique case (tx_state)
                TX_IDLE: begin
                    if (!bit_ok) begin
                        drop_cnt <= 6'h00;
                    end else if (!bit_val) begin
                        tx_state <= TX_SYNC;
                        tx_cnt   <= 6'h01;
                        scr      <= seed_ctr;
                    end else begin
                        drop_cnt <= drop_cnt + 6'h01;
                    end
                end
                TX_SYNC, TX_UMD, TX_SCR: begin
                    if (!bit_ok) begin
                        tx_state <= TX_POST;
                        tx_cnt   <= 6'h01;
                    end else if (tx_state == TX_SYNC) begin
                        tx_cnt <= (tx_cnt == SYNC_BITS - 6'h01) ? 6'h00 : tx_cnt + 6'h01;
                        if (tx_cnt == SYNC_BITS - 6'h01) begin
                            tx_state <= TX_UMD;
                        end
                    end else if (tx_state == TX_UMD) begin
                        tx_cnt <= tx_cnt + 6'h01;
                        if (tx_cnt == UMD_BITS - 6'h01) begin
                            tx_state <= TX_SCR;
                        end
                    end else begin
                        scr <= {scr[SCR_LEN-2:0], scr_b};
                    end
                end
                TX_POST: begin
                    if (tx_cnt == SQE_DELAY_BITS) begin
                        tx_state <= TX_SQE;
                        tx_cnt   <= 6'h00;
                        ce_on    <= 1'b1;
                    end else begin
                        tx_cnt <= tx_cnt + 6'h01;
                    end
                end
                TX_SQE: begin
                    tx_cnt <= tx_cnt + 6'h01;
                    if (tx_cnt == SQE_BITS - 6'h01) begin
                        tx_state <= TX_IDLE;
                        ce_on    <= 1'b0;
                        drop_cnt <= 6'h00;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                    ce_on    <= 1'b0;
                end
            endcase
        end
    end

    // Modulator side: invert, then code each bit as change or no change.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mod_bit    <= 1'b0;
            mod_strobe <= 1'b0;
            mod_on     <= 1'b0;
            tx_plain   <= 1'b1;
        end else begin
            mod_strobe <= tx_go;
            if (tx_go) begin
                tx_plain <= tx_e;
                mod_bit  <= mod_bit ^ ~tx_e;
                mod_on   <= 1'b1;
            end else if (rise && tx_state == TX_POST) begin
                mod_on <= 1'b0;  // Carrier drops before the SQE burst starts.
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive reframing: decode, descramble, refill preamble, strip postamble.

    bmf_rx_state_e         rx_state;
    logic [5:0]            rx_cnt;
    logic [5:0]            next_cnt;
    logic                  raw_prev;
    logic [SCR_LEN-1:0]    dsr;
    logic [22:0]           win;
    logic [22:0]           next_win;
    logic [21:0]           dly;
    logic [5:0]            dly_cnt;
    logic                  rx_sent;
    logic                  rx_acc;
    logic                  rec;
    logic                  desc;
    logic                  rx_push;
    logic                  rx_pb;
    logic                  rx_abort;
    logic                  emit;

    // Without carrier the recovered stream is all ones, so no delimiter forms.
    assign rx_acc   = rx_valid && rx_ready;
    assign rec      = rx_carrier ? ~(rx_raw ^ raw_prev) : 1'b1;
    assign desc     = rec ^ dsr[SCR_TAP_A-1] ^ dsr[SCR_TAP_B-1];
    assign next_win = {win[21:0], rec};
    assign next_cnt = rx_cnt + 6'h01;

    // Postamble, carrier loss or collision enforcement all end the packet.
    assign rx_abort = (rx_state != RX_IDLE) && (!rx_carrier || ce_detect
                    || (rx_acc && rx_state == RX_DATA && next_win == POSTAMBLE));

    // The delimiter's second bit is restored as a one, then the fill runs.
    always_comb begin
        rx_push = 1'b0;
        rx_pb   = rec;
        if (rx_acc && !rx_abort) begin
            unique case (rx_state)
                RX_IDLE: rx_push = rx_carrier && !rec;
                RX_SYNC: begin
                    rx_push = 1'b1;
                    rx_pb   = (next_win[5:0] == UMD_MARK) ? 1'b1 : rec;
                end
                RX_FILL: begin
                    rx_push = 1'b1;
                    rx_pb   = ~next_cnt[0];
                end
                RX_DATA: begin
                    rx_push = 1'b1;
                    rx_pb   = desc;
                end
            endcase
        end
    end

    // Descrambler and pattern window always run, so they sync on any stream.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            raw_prev <= 1'b0;
            dsr      <= 23'h000000;
            win      <= 23'h7fffff;
        end else if (rx_acc) begin
            raw_prev <= rx_raw;
            dsr      <= {dsr[SCR_LEN-2:0], rec};
            win      <= next_win;
        end
    end

    // Reframing states; the fill length covers the descrambler settling.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_state <= RX_IDLE;
            rx_cnt   <= 6'h00;
        end else if (rx_abort) begin
            rx_state <= RX_IDLE;
        end else if (rx_acc) begin
            unique case (rx_state)
                RX_IDLE: if (rx_push) rx_state <= RX_SYNC;
                RX_SYNC: begin
                    rx_cnt <= 6'h00;
                    if (next_win[5:0] == UMD_MARK) begin
                        rx_state <= RX_FILL;
                    end
                end
                RX_FILL: begin
                    rx_cnt <= next_cnt;
                    if (next_cnt == DESCR_SYNC_BITS) begin
                        rx_state <= RX_DATA;
                    end
                end
                RX_DATA: rx_cnt <= rx_cnt;
            endcase
        end
    end

    // A 22-bit lag: when the last postamble bit arrives, the held bits are
    // exactly its zero and first 21 ones, so nothing trails and no data is
    // lost; the cost is 22 bit times of receive latency.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dly     <= 22'h000000;
            dly_cnt <= 6'h00;
            rx_sent <= 1'b0;
        end else if (rx_abort) begin
            dly_cnt <= 6'h00;
            rx_sent <= 1'b0;
        end else if (rx_push) begin
            dly <= {dly[20:0], rx_pb};
            if (dly_cnt != HOLD_LEN) begin
                dly_cnt <= dly_cnt + 6'h01;
            end
            if (emit) begin
                rx_sent <= 1'b1;
            end
        end
    end

    assign emit = rx_push && dly_cnt == HOLD_LEN;

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer toward the DI encoder; a full buffer stalls the demodulator.

    bmf_di_word_s          buf_mem [BUF_DEPTH];
    logic [PW-1:0]         wr_ptr;
    logic [PW-1:0]         rd_ptr;
    logic [PW:0]           buf_cnt;
    logic                  rd_take;

    assign rx_ready = buf_cnt != (PW+1)'(BUF_DEPTH);
    assign di_valid = buf_cnt != '0;
    assign di_word  = buf_mem[rd_ptr];
    assign rd_take  = di_valid && di_ready;

    // Pointers wrap explicitly so any depth of two or more works, not only powers of two.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            buf_cnt <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem[i] <= '0;
            end
        end else begin
            if (emit) begin
                buf_mem[wr_ptr] <= '{first: !rx_sent, data: dly[21]};
                wr_ptr <= (wr_ptr == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
            end
            if (rd_take) begin
                rd_ptr <= (rd_ptr == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
            end
            buf_cnt <= buf_cnt + (PW+1)'(emit) - (PW+1)'(rd_take);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the framing, kept next to the logic above.

    logic [5:0]            nbits;
    logic [5:0]            ce_bits;

    // Helper counters: bits sent since frame start, bit times under SQE.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nbits   <= 6'h00;
            ce_bits <= 6'h00;
        end else begin
            if (tx_state == TX_IDLE) begin
                nbits <= tx_go ? 6'h01 : 6'h00;
            end else if (tx_go && nbits != 6'h3f) begin
                nbits <= nbits + 6'h01;
            end
            ce_bits <= !ce_on ? 6'h00 : (rise ? ce_bits + 6'h01 : ce_bits);
        end
    end

    a_lead_drop: assert property (@(posedge clock) disable iff (!rstn)
        $rose(tx_state == TX_SYNC) |-> $past(drop_cnt) <= MAX_LEAD_DROP)
        else $error("too many lead-in bits dropped");
    a_sync_run: assert property (@(posedge clock) disable iff (!rstn)
        $rose(tx_state == TX_SCR) |-> nbits == SYNC_BITS + UMD_BITS)
        else $error("sync run and delimiter not 22 bits");
    a_umd_zero: assert property (@(posedge clock) disable iff (!rstn)
        rise && tx_state == TX_UMD && bit_ok |=> mod_strobe && !tx_plain)
        else $error("delimiter bit not zero");
    a_post_zero: assert property (@(posedge clock) disable iff (!rstn)
        $rose(tx_state == TX_POST) |-> mod_strobe && !tx_plain)
        else $error("postamble does not open with zero");
    a_diff_code: assert property (@(posedge clock) disable iff (!rstn)
        mod_strobe |-> mod_bit == ($past(mod_bit) ^ ~tx_plain))
        else $error("modulator bit not inverted differential code");
    a_ce_excl: assert property (@(posedge clock) disable iff (!rstn)
        !(ce_on && mod_on))
        else $error("data and SQE burst overlap");
    a_sqe_len: assert property (@(posedge clock) disable iff (!rstn)
        $fell(ce_on) |-> ce_bits == SQE_BITS)
        else $error("SQE burst length wrong");
    a_sqe_delay: assert property (@(posedge clock) disable iff (!rstn)
        $rose(ce_on) |-> $past(tx_cnt) == SQE_DELAY_BITS && $past(tx_state) == TX_POST)
        else $error("SQE burst start delay wrong");
    a_descr_start: assert property (@(posedge clock) disable iff (!rstn)
        $rose(rx_state == RX_DATA) |-> rx_cnt == DESCR_SYNC_BITS)
        else $error("descrambled data not from 24th bit");
    a_fill_phase: assert property (@(posedge clock) disable iff (!rstn)
        rx_push && rx_state == RX_FILL |-> rx_pb != dly[0])
        else $error("fill pattern out of phase");
    a_post_flush: assert property (@(posedge clock) disable iff (!rstn)
        rx_acc && rx_state == RX_DATA && next_win == POSTAMBLE
        |=> rx_state == RX_IDLE && dly_cnt == 6'h00 && !emit)
        else $error("postamble bits not discarded");
    a_no_carrier: assert property (@(posedge clock) disable iff (!rstn)
        !rx_carrier && rx_state != RX_IDLE |=> rx_state == RX_IDLE && !emit)
        else $error("packet survives carrier loss");

endmodule : bmf_framing

/* File: bench/bmf_dte_model.sv */
// DTE stand-in: free-running bit clock and Manchester frames on circuit DO.
// Assumes the framing block samples both pins with its own system clock.
`timescale 1ns/1ps
module bmf_dte_model (
    output logic bit_clk,
    output logic do_line
);
    // The bit clock runs free at 160 ns, out of phase with the system clock.
    initial begin
        bit_clk = 1'b0;
        do_line = 1'b0;
        #37;
        forever #80 bit_clk = ~bit_clk;
    end

    // Frame bit k: alternating preamble that opens with a one, then mixed data.
    function automatic logic dobit(input int k, input int npre);
        logic [7:0] j;
        j = 8'(k - npre);
        return (k < npre) ? ~k[0] : (j[0] ^ j[2] ^ j[3]);
    endfunction : dobit

    // Idle carries no mid-cell edge, so the decoder sees the frame end at once.
    task automatic send(input int npre, input int ndata);
        for (int k = 0; k < npre + ndata; k++) begin
            @(posedge bit_clk) do_line <= ~dobit(k, npre);
            @(negedge bit_clk) do_line <= dobit(k, npre);
        end
        @(posedge bit_clk) do_line <= 1'b0;
    endtask : send
endmodule : bmf_dte_model

/* File: bench/tb_broadband_mau_framing.sv */
// Self-checking bench of the framing block: transmit frames, then one full and two cut receive frames.
// Assumes the DTE model in bmf_dte_model and a stalling DI encoder made here.
`timescale 1ns/1ps
module tb_broadband_mau_framing;
    import bmf_pkg::*;
    localparam int PEXT  = 5;
    localparam int NPOST = 23 + PEXT;
    typedef struct { int npre; int ndata; int npost; } bmf_row_s;
    bmf_row_s     rows [3] = '{'{62, 40, NPOST}, '{62, 40, NPOST}, '{47, 64, NPOST}};
    logic         clock, rstn, bit_clk, do_line, mod_bit, mod_strobe, mod_on, ce_on;
    logic         rx_valid, rx_raw, rx_carrier, ce_detect, rx_ready, di_valid;
    logic         di_ready = 1'b0;
    bmf_di_word_s di_word;
    int           num_errors = 0, n_compared = 0, cyc = 0, ce_rise, ce_fall;
    logic         prev_bit = 1'b0, prev_ce = 1'b0, seen_full = 1'b0, raw = 1'b0;
    logic         eq [$];
    int           ecyc [$];
    bmf_di_word_s dq [$];
    logic         body0 [23];
    logic         rv [96];

    bmf_framing #(.POST_EXT(PEXT), .BUF_DEPTH(2)) uut (.clock, .rstn, .bit_clk, .do_line,
        .mod_bit, .mod_strobe, .mod_on, .ce_on, .rx_valid, .rx_raw, .rx_carrier,
        .ce_detect, .rx_ready, .di_valid, .di_ready, .di_word);
    bmf_dte_model u_dte (.bit_clk, .do_line);

    // Free-running 125 MHz system clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Watch the line: plain bits recovered from mod_bit changes, SQE edges, DI words.
    always @(posedge clock) begin
        cyc++;
        if (mod_strobe && mod_on) begin
            eq.push_back(~(mod_bit ^ prev_bit));
            ecyc.push_back(cyc);
        end
        if (mod_strobe) prev_bit = mod_bit;
        if (ce_on && !prev_ce) ce_rise = cyc;
        if (!ce_on && prev_ce) ce_fall = cyc;
        prev_ce = ce_on;
        if (di_valid && di_ready) dq.push_back(di_word);
        if (!rx_ready) seen_full = 1'b1;
        di_ready <= #1 (cyc % 8) > 2; // Stalls 3 of 8 cycles so the buffer fills.
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("errors %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // Data of the rebuilt frame: alternating preamble up to bit 62, mixed after.
    function automatic logic dv(input int i);
        return (i < 62) ? i[0] : (i[0] ^ i[2] ^ i[3]);
    endfunction : dv

    // Raw bits are differentially coded here so that the block recovers rb.
    task automatic rx_bit(input logic c, input logic rb);
        int n = 0;
        if (c) raw = raw ^ ~rb;
        rx_valid = 1'b1;
        rx_carrier = c;
        rx_raw = raw;
        while (!rx_ready && n < 100) begin
            @(posedge clock); #1; n++;
        end
        if (n == 100) begin
            num_errors++;
            give_verdict();
        end
        @(posedge clock); #1;
    endtask : rx_bit

    // A hang anywhere counts as a mismatch.
    initial begin
        repeat (90000) @(posedge clock);
        num_errors++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence: reset, table of transmit frames, then the full receive frame and two cut ones.
    initial begin
        rstn = 1'b0;
        {rx_valid, rx_raw, rx_carrier, ce_detect} = 4'h0;
        repeat (20) @(posedge clock);
        check({mod_bit, mod_strobe, mod_on, ce_on, rx_ready, di_valid, di_word}, 8'h08);
        #1 rstn = 1'b1;
        for (int r = 0; r < 3; r++) begin
            int   n, z, nb, w;
            logic diff;
            eq.delete();
            ecyc.delete();
            u_dte.send(rows[r].npre, rows[r].ndata);
            w = 0;
            while (!ce_on && w < 3000) begin
                @(posedge clock); #1; w++;
            end
            while (ce_on && w < 3000) begin
                @(posedge clock); #1; w++;
            end
            if (w == 3000) begin
                num_errors++;
                give_verdict();
            end
            @(posedge clock); #1;
            n = eq.size();
            nb = n - rows[r].npost - 22;
            z = rows[r].npre + rows[r].ndata - (n - rows[r].npost);
            check(z >= 0 && z <= 5, 1);
            for (int k = 0; k < 22; k++) check(eq[k], (k < 20) ? k % 2 : 0);
            for (int j = 23; j < nb; j++)
                check(eq[22+j] ^ eq[4+j] ^ eq[j-1], u_dte.dobit(z+22+j, rows[r].npre));
            for (int k = 0; k < rows[r].npost; k++)
                check(eq[n-rows[r].npost+k], k > 0);
            check((ce_rise - ecyc[n-rows[r].npost]) inside {[640:760]}, 1);
            check((ce_fall - ce_rise) inside {[580:620]}, 1);
            diff = 1'b0;
            for (int k = 0; k < 23; k++) begin
                diff |= (r == 1) && (eq[22+k] !== body0[k]);
                body0[k] = eq[22+k];
            end
            if (r == 1) check(diff, 1);
        end
        // Receive: sync, delimiter, 23 filler bits, then scrambled data and postamble.
        for (int i = 0; i < 96; i++)
            rv[i] = (i < 20) ? i[0] : (i < 45) ? 1'b0 : dv(i) ^ rv[i-18] ^ rv[i-23];
        repeat (5) rx_bit(1'b0, 1'b0);
        for (int i = 0; i < 96; i++) rx_bit(1'b1, rv[i]);
        rx_bit(1'b1, 1'b0);
        repeat (22) rx_bit(1'b1, 1'b1);
        repeat (5) rx_bit(1'b0, 1'b0);
        rx_valid = 1'b0;
        for (int w = 0; w < 50 && di_valid; w++) begin
            @(posedge clock); #1;
        end
        check(dq.size(), 96);
        for (int i = 0; i < dq.size(); i++)
            check(dq[i], {i == 0, dv(i)});
        check(seen_full, 1'b1);
        // Cut frames: collision enforcement, then carrier loss, at bit 40 each.
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 41; i++) begin
                ce_detect = (f == 0 && i == 40);
                rx_bit(!(f == 1 && i == 40), rv[i]);
            end
            ce_detect = 1'b0;
            repeat (3) rx_bit(1'b0, 1'b0);
        end
        rx_valid = 1'b0;
        for (int w = 0; w < 50 && di_valid; w++) begin
            @(posedge clock); #1;
        end
        check(dq.size(), 132);
        for (int i = 0; i < 36; i++)
            check(dq[96+i], {i % 18 == 0, dv(i % 18)});
        give_verdict();
    end
endmodule : tb_broadband_mau_framing
